// ---- core/dio_route.sv ----
// digital input/output routing core with object-dictionary access port
`timescale 1ns/1ps
`default_nettype none
`include "dio_route_regs.svh"
module dio_route #(
  parameter int unsigned SAMPLE_CYCLES = `DIO_SAMPLE_NS / `DIO_CLK_NS
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic [5:0]                dio_i,
  output logic      [3:0]                dio_o,
  output logic      [3:0]                dio_oe_n_o,
  output logic                           brake_o,
  input  wire logic [2:0]                hall_i,
  input  wire logic [2:0]                enc_line_i,
  input  wire logic                      enc_step_i,
  input  wire logic                      pos_step_i,
  input  wire logic                      brake_pwm_i,
  input  wire logic                      od_wr_i,
  input  wire logic                      od_rd_i,
  input  wire logic [15:0]               od_idx_i,
  input  wire logic [7:0]                od_sub_i,
  input  wire dio_route_pkg::dio_word_t  od_wdata_i,
  output dio_route_pkg::dio_word_t       od_rdata_o,
  output logic                           od_ack_o,
  output logic                           od_err_o
);
  import dio_route_pkg::*;

  dio_word_t      spec_en_q, inv_q, force_en_q, force_val_q, di_q, do_q;
  dio_word_t      pol_q, man_en_q, man_val_q, unused1_q, unused5_q, rdata_q;
  dio_in_code_t   in_route_q [32];
  dio_out_route_t out_route_q [5];
  logic           in_route_en_q, out_route_en_q, ack_q, err_q;
  logic [3:0]     pin_mask_q;
  logic [5:0]     samp_q, filt_q;
  logic [4:0]     out_q;
  logic [6:0]     enc_div_q, pos_div_q;
  logic [31:0]    tick_cnt_q;
  logic           tick;
  logic           wr_in_cfg, wr_out_cfg, in_en_wr;
  logic [15:0]    phys;

  // decode of one input route code, undefined codes give zero
  function automatic logic in_src(input dio_in_code_t c, input logic [15:0] p,
                                  input logic [2:0] h, input logic [2:0] e);
    logic [6:0] s;
    logic       v;
    logic       ok;
    s  = c[6:0];
    v  = 1'b0;
    ok = 1'b1;
    if (s >= 7'h01 && s <= 7'h10) begin
      v = p[4'(s - 7'h01)];
    end else if (s >= 7'h41 && s <= 7'h43) begin
      v = h[2'(s - 7'h41)];
    end else if (s >= 7'h44 && s <= 7'h46) begin
      v = e[2'(s - 7'h44)];
    end else if (s != 7'h00) begin
      ok = 1'b0;
    end
    return ok & (v ^ c[7]);
  endfunction

  // table code that reproduces the normal-mode behaviour of word bit b
  function automatic dio_in_code_t preload(input int b, input dio_word_t sp,
      input dio_word_t iv, input dio_word_t fe, input dio_word_t fv);
    dio_in_code_t c;
    c = `DIO_RST_CODE;
    if (b >= 16 && b < 22) begin
      c = fe[b] ? {fv[b], 7'h00} : {iv[b], 7'(b - 15)};
    end else if (b < 6 && sp[b]) begin
      c = fe[b] ? {fv[b], 7'h00} : {iv[b], 7'(b + 1)};
    end
    return c;
  endfunction

  // decode of one output route entry: source selected by high byte, gated by low byte
  function automatic logic out_src(input dio_out_route_t r, input dio_word_t dw,
      input logic [6:0] ed, input logic [6:0] pd, input logic pwm);
    logic s;
    logic [7:0] h;
    h = r[15:8];
    s = 1'b0;
    if (h == 8'h00) begin
      s = 1'b1;
    end else if (h >= 8'h02 && h <= 8'h08) begin
      s = ed[3'(h - 8'h02)];
    end else if (h >= 8'h09 && h <= 8'h0f) begin
      s = pd[3'(h - 8'h09)];
    end else if (h == 8'h10) begin
      s = pwm;
    end else if (h == 8'h11) begin
      s = ~pwm;
    end
    return s & (dw[r[4:0]] ^ r[7]);
  endfunction

  assign wr_in_cfg  = od_wr_i && od_idx_i == `DIO_IDX_IN_CFG;
  assign wr_out_cfg = od_wr_i && od_idx_i == `DIO_IDX_OUT_CFG;
  assign in_en_wr   = wr_in_cfg && od_sub_i == `DIO_SUB_ROUTE_EN;
  assign phys       = {10'h000, filt_q};
  assign tick       = tick_cnt_q == 32'(SAMPLE_CYCLES - 1);

  // millisecond sampling tick
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // two agreeing samples a tick apart are needed, so sub-millisecond pulses die here
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      samp_q <= 6'h00;
      filt_q <= 6'h00;
    end else if (tick) begin
      samp_q <= dio_i;
      for (int i = 0; i < 6; i++) begin
        if (dio_i[i] == samp_q[i]) begin
          filt_q[i] <= dio_i[i];
        end
      end
    end
  end

  // input configuration object
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      spec_en_q     <= `DIO_RST_WORD;
      inv_q         <= `DIO_RST_WORD;
      force_en_q    <= `DIO_RST_WORD;
      force_val_q   <= `DIO_RST_WORD;
      in_route_en_q <= 1'b0;
    end else if (wr_in_cfg) begin
      unique case (od_sub_i)
        `DIO_SUB_SPECIAL_EN: spec_en_q   <= od_wdata_i;
        `DIO_SUB_INVERT:     inv_q       <= od_wdata_i;
        `DIO_SUB_FORCE_EN:   force_en_q  <= od_wdata_i;
        `DIO_SUB_FORCE_VAL:  force_val_q <= od_wdata_i;
        `DIO_SUB_ROUTE_EN:   in_route_en_q <= od_wdata_i[0];
        default: ;
      endcase
    end
  end

  // input route table; switching routing on snapshots the normal-mode function
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int b = 0; b < 32; b++) begin
        in_route_q[b] <= `DIO_RST_CODE;
      end
    end else if (in_en_wr && od_wdata_i[0] && !in_route_en_q) begin
      for (int b = 0; b < 32; b++) begin
        in_route_q[b] <= preload(b, spec_en_q, inv_q, force_en_q, force_val_q);
      end
    end else if (od_wr_i && od_idx_i == `DIO_IDX_IN_ROUTE && od_sub_i >= 8'h01
                 && od_sub_i <= 8'h20) begin
      in_route_q[5'(od_sub_i - 8'h01)] <= od_wdata_i[7:0];
    end
  end

  // digital-inputs word, refreshed at every sampling tick
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      di_q <= `DIO_RST_WORD;
    end else if (tick) begin
      for (int b = 0; b < 32; b++) begin
        if (in_route_en_q) begin
          di_q[b] <= in_src(in_route_q[b], phys, hall_i, enc_line_i);
        end else if (b >= 16 && b < 22) begin
          di_q[b] <= force_en_q[b] ? force_val_q[b] : phys[4'(b - 16)] ^ inv_q[b];
        end else if (b < 6) begin
          di_q[b] <= spec_en_q[b] & (force_en_q[b] ? force_val_q[b] : filt_q[b] ^ inv_q[b]);
        end else begin
          di_q[b] <= 1'b0;
        end
      end
    end
  end

  // output word, output configuration, pin direction mask
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      do_q           <= `DIO_RST_WORD;
      pol_q          <= `DIO_RST_WORD;
      man_en_q       <= `DIO_RST_WORD;
      man_val_q      <= `DIO_RST_WORD;
      unused1_q      <= `DIO_RST_WORD;
      unused5_q      <= `DIO_RST_WORD;
      out_route_en_q <= 1'b0;
      pin_mask_q     <= 4'h0;
    end else begin
      if (od_wr_i && od_idx_i == `DIO_IDX_DO_WORD && od_sub_i == `DIO_SUB_DO_WORD) begin
        do_q <= od_wdata_i;
      end
      if (od_wr_i && od_idx_i == `DIO_IDX_PIN_DIR && od_sub_i == `DIO_SUB_PIN_MASK) begin
        pin_mask_q <= od_wdata_i[3:0];
      end
      if (wr_out_cfg) begin
        unique case (od_sub_i)
          `DIO_SUB_OUT_UNUSED1: unused1_q <= od_wdata_i;
          `DIO_SUB_POLARITY:    pol_q     <= od_wdata_i;
          `DIO_SUB_MAN_EN:      man_en_q  <= od_wdata_i;
          `DIO_SUB_MAN_VAL:     man_val_q <= od_wdata_i;
          `DIO_SUB_OUT_UNUSED5: unused5_q <= od_wdata_i;
          `DIO_SUB_ROUTE_EN:    out_route_en_q <= od_wdata_i[0];
          default: ;
        endcase
      end
    end
  end

  // output route table
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int j = 0; j < 5; j++) begin
        out_route_q[j] <= `DIO_RST_ROUTE16;
      end
    end else if (od_wr_i && od_idx_i == `DIO_IDX_OUT_ROUTE && od_sub_i >= 8'h01
                 && od_sub_i <= 8'h05) begin
      out_route_q[3'(od_sub_i - 8'h01)] <= od_wdata_i[15:0];
    end
  end

  // divider counters on encoder and position steps
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      enc_div_q <= 7'h00;
      pos_div_q <= 7'h00;
    end else begin
      enc_div_q <= enc_div_q + 7'(enc_step_i);
      pos_div_q <= pos_div_q + 7'(pos_step_i);
    end
  end

  // output pins: full-clock update keeps every pin far above 10 khz
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_q <= 5'h00;
    end else begin
      for (int j = 0; j < 5; j++) begin
        automatic int  p = (j == 0) ? `DIO_POS_BRAKE : `DIO_POS_OUT1 + j - 1;
        automatic logic base = out_route_en_q ?
            out_src(out_route_q[j], do_q, enc_div_q, pos_div_q, brake_pwm_i) : do_q[p];
        out_q[j] <= man_en_q[p] ? man_val_q[p] : base ^ pol_q[p];
      end
    end
  end

  assign dio_o      = out_q[4:1];
  assign dio_oe_n_o = ~pin_mask_q;
  assign brake_o    = out_q[0];

  // read port with one-cycle answer; unknown objects flag an error
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= `DIO_RST_WORD;
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      ack_q <= od_wr_i | od_rd_i;
      err_q <= 1'b0;
      if (od_rd_i) begin
        rdata_q <= `DIO_RST_WORD;
        unique case (od_idx_i)
          `DIO_IDX_IN_CFG: begin
            unique case (od_sub_i)
              `DIO_SUB_SPECIAL_EN: rdata_q <= spec_en_q;
              `DIO_SUB_INVERT:     rdata_q <= inv_q;
              `DIO_SUB_FORCE_EN:   rdata_q <= force_en_q;
              `DIO_SUB_FORCE_VAL:  rdata_q <= force_val_q;
              `DIO_SUB_RAW:        rdata_q <= {10'h000, filt_q, 16'h0000};
              `DIO_SUB_ROUTE_EN:   rdata_q <= {31'h0, in_route_en_q};
              default:             err_q   <= 1'b1;
            endcase
          end
          `DIO_IDX_IN_ROUTE: begin
            if (od_sub_i >= 8'h01 && od_sub_i <= 8'h20) begin
              rdata_q <= {24'h0, in_route_q[5'(od_sub_i - 8'h01)]};
            end else begin
              err_q <= 1'b1;
            end
          end
          `DIO_IDX_OUT_ROUTE: begin
            if (od_sub_i >= 8'h01 && od_sub_i <= 8'h05) begin
              rdata_q <= {16'h0, out_route_q[3'(od_sub_i - 8'h01)]};
            end else begin
              err_q <= 1'b1;
            end
          end
          `DIO_IDX_OUT_CFG: begin
            unique case (od_sub_i)
              `DIO_SUB_OUT_UNUSED1: rdata_q <= unused1_q;
              `DIO_SUB_POLARITY:    rdata_q <= pol_q;
              `DIO_SUB_MAN_EN:      rdata_q <= man_en_q;
              `DIO_SUB_MAN_VAL:     rdata_q <= man_val_q;
              `DIO_SUB_OUT_UNUSED5: rdata_q <= unused5_q;
              `DIO_SUB_ROUTE_EN:    rdata_q <= {31'h0, out_route_en_q};
              default:              err_q   <= 1'b1;
            endcase
          end
          `DIO_IDX_DI_WORD:  rdata_q <= di_q;
          `DIO_IDX_DO_WORD:  rdata_q <= do_q;
          `DIO_IDX_PIN_DIR:  rdata_q <= {28'h0, pin_mask_q};
          default:           err_q   <= 1'b1;
        endcase
      end
    end
  end

  assign od_rdata_o = rdata_q;
  assign od_ack_o   = ack_q;
  assign od_err_o   = err_q;

  // checks on the routing behaviour
  AST_PRELOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (in_en_wr && od_wdata_i[0] && !in_route_en_q && !force_en_q[16])
    |=> in_route_q[16] == {$past(inv_q[16]), 7'h01}) else $error("preload of bit 16 wrong");
  AST_FORCE_IGNORED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (in_route_en_q && tick && in_route_q[16] == 8'h81 && force_en_q[16] && force_val_q[16])
    |=> di_q[16] == !$past(filt_q[0])) else $error("force acted while routing");
  AST_IN_PHYS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (in_route_en_q && tick && in_route_q[0] == 8'h01) |=> di_q[0] == $past(filt_q[0]))
    else $error("routed pin 1 not on bit 0");
  AST_IN_ONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (in_route_en_q && tick && in_route_q[2] == 8'h80) |=> di_q[2])
    else $error("code 80 not one");
  AST_IN_BAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (in_route_en_q && tick && in_route_q[0] == 8'h20) |=> !di_q[0])
    else $error("undefined code not zero");
  AST_OUT_PIN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!out_route_en_q && !man_en_q[17] && !pol_q[17]) |=> out_q[2] == $past(do_q[17]))
    else $error("output 2 not from bit 17");
  AST_OUT_POL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!out_route_en_q && !man_en_q[17] && pol_q[17] && do_q[17]) |=> !out_q[2])
    else $error("polarity not applied");
  AST_OVR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    man_en_q[0] |=> brake_o == $past(man_val_q[0])) else $error("brake override lost");
  AST_CONST0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (out_route_en_q && !man_en_q[16] && !pol_q[16] && out_route_q[1][15:8] == 8'h01)
    |=> !out_q[1]) else $error("source 01 not low");
endmodule
`default_nettype wire

// ---- core/dio_route_regs.svh ----
// constants of the digital i/o routing block: object indices, subindices, resets, timing
`ifndef DIO_ROUTE_REGS_SVH
`define DIO_ROUTE_REGS_SVH
`define DIO_IDX_IN_CFG      16'h3240
`define DIO_IDX_IN_ROUTE    16'h3242
`define DIO_IDX_DI_WORD     16'h60fd
`define DIO_IDX_DO_WORD     16'h60fe
`define DIO_IDX_OUT_CFG     16'h3250
`define DIO_IDX_OUT_ROUTE   16'h3252
`define DIO_IDX_PIN_DIR     16'h3231
`define DIO_SUB_SPECIAL_EN  8'h01
`define DIO_SUB_INVERT      8'h02
`define DIO_SUB_FORCE_EN    8'h03
`define DIO_SUB_FORCE_VAL   8'h04
`define DIO_SUB_RAW         8'h05
`define DIO_SUB_ROUTE_EN    8'h08
`define DIO_SUB_OUT_UNUSED1 8'h01
`define DIO_SUB_POLARITY    8'h02
`define DIO_SUB_MAN_EN      8'h03
`define DIO_SUB_MAN_VAL     8'h04
`define DIO_SUB_OUT_UNUSED5 8'h05
`define DIO_SUB_PIN_MASK    8'h01
`define DIO_SUB_DO_WORD     8'h01
`define DIO_POS_OUT1        16
`define DIO_POS_BRAKE       0
`define DIO_RST_WORD        32'h0000_0000
`define DIO_RST_ROUTE16     16'h0000
`define DIO_RST_CODE        8'h00
`define DIO_CLK_NS          50
`define DIO_SAMPLE_NS       1000000
`endif

// ---- core/dio_route_pkg.sv ----
// types shared by the digital i/o routing block
package dio_route_pkg;
  typedef logic [7:0]  dio_in_code_t;
  typedef logic [15:0] dio_out_route_t;
  typedef logic [31:0] dio_word_t;
endpackage

// ---- test/dio_route_pins.sv ----
// model of the pins around the digital i/o routing block
`timescale 1ns/1ps
`default_nettype none
module dio_route_pins (
  input  wire logic [5:0] lvl_i,
  input  wire logic [3:0] drv_i,
  input  wire logic [3:0] oe_n_i,
  output logic      [5:0] pin_o
);
  // a pin switched to output shows what the block drives, so the
  // outside switch is taken as released there to avoid contention
  always_comb begin
    pin_o[5:4] = lvl_i[5:4];
    for (int k = 0; k < 4; k++) begin
      pin_o[k] = oe_n_i[k] ? lvl_i[k] : drv_i[k];
    end
  end
endmodule
`default_nettype wire

// ---- test/dio_route_tb.sv ----
// self-checking bench for the digital i/o routing block
`timescale 1ns/1ps
`default_nettype none
`include "dio_route_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module dio_route_tb;
  import dio_route_pkg::*;
  localparam int unsigned SC = 8; // short tick keeps the run brief
  localparam int unsigned ST = 3 * SC + 2; // two equal ticks plus update
  logic [15:0] cfi = `DIO_IDX_IN_CFG;
  logic [15:0] rti = `DIO_IDX_IN_ROUTE;
  logic [15:0] diw = `DIO_IDX_DI_WORD;
  logic [15:0] dow = `DIO_IDX_DO_WORD;
  logic [15:0] cfo = `DIO_IDX_OUT_CFG;
  logic [15:0] rto = `DIO_IDX_OUT_ROUTE;
  logic [15:0] pdr = `DIO_IDX_PIN_DIR;
  logic        clk_i, rst_n_i, brake_o, enc_step_i, pos_step_i, brake_pwm_i;
  logic        od_wr_i, od_rd_i, od_ack_o, od_err_o, rerr;
  logic [5:0]  dio_i, lvl;
  logic [3:0]  dio_o, dio_oe_n_o;
  logic [2:0]  hall_i, enc_line_i;
  logic [15:0] od_idx_i;
  logic [7:0]  od_sub_i;
  dio_word_t   od_wdata_i, od_rdata_o, rdat;
  int          fail_count, n_compared, ecnt, pcnt;

  dio_route #(.SAMPLE_CYCLES(SC)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .dio_i(dio_i),
    .dio_o(dio_o), .dio_oe_n_o(dio_oe_n_o), .brake_o(brake_o), .hall_i(hall_i),
    .enc_line_i(enc_line_i), .enc_step_i(enc_step_i), .pos_step_i(pos_step_i),
    .brake_pwm_i(brake_pwm_i), .od_wr_i(od_wr_i), .od_rd_i(od_rd_i), .od_idx_i(od_idx_i),
    .od_sub_i(od_sub_i), .od_wdata_i(od_wdata_i), .od_rdata_o(od_rdata_o),
    .od_ack_o(od_ack_o), .od_err_o(od_err_o));
  dio_route_pins pins (.lvl_i(lvl), .drv_i(dio_o), .oe_n_i(dio_oe_n_o), .pin_o(dio_i));

  // free-running 20 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // one-cycle write strobe, then one more edge so outputs have settled
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input dio_word_t d);
    cyc(1);
    od_wr_i = 1'b1;
    od_idx_i = idx;
    od_sub_i = sub;
    od_wdata_i = d;
    cyc(1);
    od_wr_i = 1'b0;
    cyc(1);
  endtask

  // answer stands for the cycle after the taking edge
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub);
    cyc(1);
    od_rd_i = 1'b1;
    od_idx_i = idx;
    od_sub_i = sub;
    cyc(1);
    od_rd_i = 1'b0;
    `CHK("ack", 1'b1, od_ack_o)
    rdat = od_rdata_o;
    rerr = od_err_o;
  endtask

  task automatic pulse(input logic pos, input int n);
    repeat (n) begin
      cyc(1);
      if (pos) pos_step_i = 1'b1;
      else enc_step_i = 1'b1;
      cyc(1);
      pos_step_i = 1'b0;
      enc_step_i = 1'b0;
    end
  endtask

  task automatic t_reset();
    `CHK("pins", 5'h00, {dio_o, brake_o})
    `CHK("oe_n", 4'hf, dio_oe_n_o)
    for (int s = 1; s <= 5; s++) begin
      rd(rto, 8'(s));
      `CHK("route rst", 32'h0000_0000, rdat)
      wr(rto, 8'(s), 32'h0000_a5c0 + 32'(s));
      rd(rto, 8'(s));
      `CHK("route rw", 32'h0000_a5c0 + 32'(s), rdat)
      wr(rto, 8'(s), 32'h0000_0000);
    end
    rd(16'h1234, 8'h01);
    `CHK("unmapped", 33'h1_0000_0000, {rerr, rdat})
    wr(pdr, 8'h01, 32'h0000_003f);
    rd(pdr, 8'h01);
    `CHK("pin mask", 32'h0000_000f, rdat)
    `CHK("oe_n", 4'h0, dio_oe_n_o)
  endtask

  task automatic t_outputs();
    wr(dow, 8'h01, 32'h0005_0001);
    `CHK("out word", 5'h0b, {dio_o, brake_o})
    wr(dow, 8'h01, 32'h000a_0000);
    `CHK("out word", 5'h14, {dio_o, brake_o})
    wr(cfo, 8'h02, 32'h0003_0000);
    `CHK("polarity", 5'h12, {dio_o, brake_o})
    wr(cfo, 8'h03, 32'h0004_0001);
    wr(cfo, 8'h04, 32'h0004_0001);
    `CHK("manual", 5'h1b, {dio_o, brake_o})
    wr(cfo, 8'h01, 32'hffff_ffff);
    wr(cfo, 8'h05, 32'hffff_ffff);
    `CHK("no effect", 5'h1b, {dio_o, brake_o})
    wr(cfo, 8'h02, 32'h0000_0000);
    wr(cfo, 8'h03, 32'h0000_0000);
  endtask

  task automatic t_inputs();
    wr(dow, 8'h01, 32'h0006_0000);
    lvl = 6'b100101;
    cyc(ST);
    rd(diw, 8'h00);
    `CHK("readback", 6'b100110, rdat[21:16])
    wr(pdr, 8'h01, 32'h0000_0000);
    cyc(ST);
    rd(diw, 8'h00);
    `CHK("levels", 6'b100101, rdat[21:16])
    lvl[1] = 1'b1;
    cyc(3);
    lvl[1] = 1'b0;
    cyc(ST);
    rd(diw, 8'h00);
    `CHK("glitch", 6'b100101, rdat[21:16])
    // special enable on bit 0 only, bit 17 forced high against a low pin
    wr(cfi, 8'h01, 32'h0000_0001);
    wr(cfi, 8'h03, 32'h0002_0000);
    wr(cfi, 8'h04, 32'h0002_0000);
    cyc(SC + 2);
    rd(diw, 8'h00);
    `CHK("special force", 4'b1101, {rdat[17:16], rdat[1:0]})
    rd(cfi, 8'h05);
    `CHK("raw", 32'h0025_0000, rdat)
    wr(cfi, 8'h01, 32'h0000_0000);
    wr(cfi, 8'h03, 32'h0000_0000);
  endtask

  task automatic t_in_route();
    logic [7:0] cd [14] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h41, 8'h42, 8'h43,
                            8'h44, 8'h45, 8'h46, 8'h80, 8'h81, 8'hc6, 8'h20};
    logic       ex [14] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1,
                            1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    wr(cfi, 8'h02, 32'h0001_0000);
    cyc(ST);
    rd(diw, 8'h00);
    `CHK("inverted in1", 1'b0, rdat[16])
    wr(cfi, 8'h08, 32'h0000_0001);
    rd(rti, 8'h11);
    `CHK("preload in1", 32'h0000_0081, rdat)
    rd(rti, 8'h16);
    `CHK("preload in6", 32'h0000_0006, rdat)
    wr(cfi, 8'h03, 32'h0001_0000);
    wr(cfi, 8'h04, 32'h0001_0000);
    wr(cfi, 8'h02, 32'h0000_0000);
    cyc(ST);
    rd(diw, 8'h00);
    `CHK("config ignored", 1'b0, rdat[16])
    for (int i = 0; i < 14; i++) begin
      wr(rti, 8'h01, 32'(cd[i]));
      cyc(SC + 2);
      rd(diw, 8'h00);
      `CHK("routed bit0", ex[i], rdat[0])
    end
    wr(rti, 8'h03, 32'h0000_0080);
    cyc(SC + 2);
    rd(diw, 8'h00);
    `CHK("routed bit2", 2'b10, {rdat[2], rdat[0]})
  endtask

  task automatic t_out_route();
    logic [15:0] rt [8] = '{16'h0005, 16'h0005, 16'h0085, 16'h0105,
                            16'h1000, 16'h1000, 16'h1100, 16'h1180};
    logic [7:0]  dw [8] = '{8'h20, 8'h00, 8'h00, 8'h20, 8'h01, 8'h01, 8'h01, 8'h00};
    logic        pw [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic        ex [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    wr(pdr, 8'h01, 32'h0000_000f);
    wr(dow, 8'h01, 32'h0001_0000);
    wr(rto, 8'h02, 32'h0000_0105);
    `CHK("routing off", 1'b1, dio_o[0])
    wr(cfo, 8'h08, 32'h0000_0001);
    `CHK("routing on", 1'b0, dio_o[0])
    for (int i = 0; i < 8; i++) begin
      brake_pwm_i = pw[i];
      wr(dow, 8'h01, 32'(dw[i]));
      wr(rto, 8'h02, 32'(rt[i]));
      `CHK("route out1", ex[i], dio_o[0])
    end
    wr(dow, 8'h01, 32'h0000_0020);
    for (int s = 1; s <= 5; s++) wr(rto, 8'(s), s[0] ? 32'h0000_0005 : 32'h0000_0105);
    `CHK("route map", 5'h15, {dio_o, brake_o})
    for (int k = 0; k < 7; k++) begin
      wr(rto, 8'h02, {16'h0000, 8'(2 + k), 8'h05});
      wr(rto, 8'h03, {16'h0000, 8'(9 + k), 8'h05});
      pulse(1'b0, 37);
      pulse(1'b1, 29);
      ecnt += 37;
      pcnt += 29;
      cyc(2);
      `CHK("dividers", {pcnt[k], ecnt[k]}, dio_o[1:0])
    end
  endtask

  task automatic results();
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog well beyond the expected run of under two thousand cycles
  initial begin
    #(50 * 40000);
    fail_count++;
    results();
  end

  initial begin
    rst_n_i = 1'b0;
    {od_wr_i, od_rd_i, enc_step_i, pos_step_i, brake_pwm_i} = 5'h00;
    od_idx_i = 16'h0000;
    od_sub_i = 8'h00;
    od_wdata_i = 32'h0000_0000;
    lvl = 6'h00;
    hall_i = 3'h5;
    enc_line_i = 3'h2;
    fail_count = 0;
    n_compared = 0;
    ecnt = 0;
    pcnt = 0;
    cyc(10);
    rst_n_i = 1'b1;
    t_reset();
    t_outputs();
    t_inputs();
    t_in_route();
    t_out_route();
    results();
  end
endmodule
`default_nettype wire
